// ---- hw/rsm_byte_pair.sv ----
// pairs the incoming byte stream into code and qualifier
// assumes bytes arrive from a receiver on the same clock, one per cycle with valid high
`timescale 1ns/1ps
module rsm_byte_pair (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // byte stream
    input  wire logic [7:0] rx_byte_i,
    input  wire logic       rx_valid_i,
    // paired command
    output logic      [7:0] code_o,
    output logic      [7:0] qual_o,
    output logic            cmd_valid_o
);

    logic have_code_reg;

    // first byte is the code, second the qualifier
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            have_code_reg <= 1'b0;
            code_o        <= 8'h00;
            qual_o        <= 8'h00;
        end else if (rx_valid_i) begin
            have_code_reg <= ~have_code_reg;
            if (!have_code_reg) begin
                code_o <= rx_byte_i;
            end else begin
                qual_o <= rx_byte_i;
            end
        end
    end

    // pulse only once both bytes are in
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_valid_o <= 1'b0;
        end else begin
            cmd_valid_o <= rx_valid_i & have_code_reg;
        end
    end

endmodule

// ---- hw/rsm_cmd_core.sv ----
// sound and motor command interpreter
// assumes rx bytes come from a serial receiver on clk_i; drive requests from
// the motion logic on clk_i; sound_o drives a piezo buzzer
`timescale 1ns/1ps
`include "rsm_cfg.svh"

// Notes on behaviour
// - after reset the start-up effect plays once on the buzzer.
// - the robot initialisation command replays that same start-up effect.
// - each command is exactly two bytes and nothing acts before both are in.
// - the first byte is the command code and the second qualifies it.
// - a sound command with an effect qualifier plays one of the ten effects.
// - a note qualifier picks c to b in the lower, middle or upper octave.
// - the note length field picks double, whole, half or quarter duration.
// - motor drive outputs stay off until a motor configuration has arrived.
// - the motor type comes only from the three low qualifier bits.
// - type zero means small brushed motors driven straight from the pins.
// - a separate qualifier bit turns on encoder operation.
module rsm_cmd_core #(
    parameter int CLK_HZ         = `RSM_CLK_HZ,
    parameter int QUARTER_MS     = `RSM_QUARTER_NOTE_MS,
    parameter int EFFECT_STEP_MS = `RSM_EFFECT_STEP_MS,
    parameter int HP_W           = 20
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // command byte stream
    input  wire logic [7:0] rx_byte_i,
    input  wire logic       rx_valid_i,
    // drive requests from motion logic
    input  wire logic [1:0] left_drive_i,
    input  wire logic [1:0] right_drive_i,
    // motor pins and configuration
    output logic      [1:0] left_drive_o,
    output logic      [1:0] right_drive_o,
    output logic            motor_configured_o,
    output logic      [2:0] motor_type_o,
    output logic            encoder_en_o,
    output logic            direct_drive_o,
    // sound
    output logic            sound_o,
    output logic            sound_active_o,
    // command status
    output logic            cmd_taken_o,
    output logic            cmd_ignored_o
);

    // timing counts from the clock rate
    localparam int QUARTER_CYCLES = (CLK_HZ / `RSM_MS_PER_S) * QUARTER_MS;
    localparam int STEP_CYCLES    = (CLK_HZ / `RSM_MS_PER_S) * EFFECT_STEP_MS;
    localparam int LOWEST_HZ      = `RSM_NOTE_C_HZ / 2;

    if (QUARTER_CYCLES < 1 || STEP_CYCLES < 1) begin : g_chk_time
        $error("note or effect step shorter than one clock");
    end
    if (CLK_HZ / (2 * LOWEST_HZ) >= (1 << HP_W)) begin : g_chk_hp
        $error("half period width too small for the clock rate");
    end
    if (CLK_HZ / (4 * `RSM_NOTE_B_HZ) < 1) begin : g_chk_hz
        $error("clock too slow for the upper octave");
    end

    // frequency of a pitch index: middle octave value, halved for the lower octave, doubled for the upper
    function automatic int note_hz(input int idx);
        int f;
        f = `RSM_NOTE_C_HZ;
        case (idx % `RSM_NOTES_PER_OCTAVE)
            0: f = `RSM_NOTE_C_HZ;
            1: f = `RSM_NOTE_D_HZ;
            2: f = `RSM_NOTE_E_HZ;
            3: f = `RSM_NOTE_F_HZ;
            4: f = `RSM_NOTE_G_HZ;
            5: f = `RSM_NOTE_A_HZ;
            default: f = `RSM_NOTE_B_HZ;
        endcase
        if (idx < `RSM_NOTES_PER_OCTAVE) begin
            f = f / 2;
        end else if (idx >= 2 * `RSM_NOTES_PER_OCTAVE) begin
            f = f * 2;
        end
        return f;
    endfunction

    // pitch sequence of each effect, one step per effect step time
    function automatic logic [4:0] efx_pitch(input logic [3:0] e, input logic [2:0] s);
        logic [4:0] p;
        p = `RSM_PITCH_END;
        case (e)
            `RSM_DRIP_EFFECT_A: begin
                if (s == 3'h0) p = 5'h14;
                else if (s == 3'h1) p = 5'h10;
            end
            `RSM_DRIP_EFFECT_B: begin
                if (s == 3'h0) p = 5'h12;
                else if (s == 3'h1) p = 5'h0B;
            end
            `RSM_STARTUP_EFFECT: begin
                if (s == 3'h0) p = 5'h07;
                else if (s == 3'h1) p = 5'h09;
                else if (s == 3'h2) p = 5'h0B;
                else if (s == 3'h3) p = 5'h0E;
            end
            `RSM_LOW_PITCH_EFFECT: begin
                if (s <= 3'h5) p = 5'h00;
            end
            `RSM_DOUBLE_CHIRP_EFFECT: begin
                if (s <= 3'h2) p = s[0] ? `RSM_PITCH_REST : 5'h13;
            end
            `RSM_TRIPLE_CHIRP_EFFECT: begin
                if (s <= 3'h4) p = s[0] ? `RSM_PITCH_REST : 5'h13;
            end
            `RSM_PHASOR_EFFECT: begin
                if (s <= 3'h5) p = s[0] ? 5'h14 : 5'h0E;
            end
            `RSM_WAIL_EFFECT_A: begin
                p = (s[2] ? 5'h0F : 5'h07) + {2'b00, s[2] ? ~s : s} - {2'b00, s[2], 2'b00};
            end
            `RSM_WAIL_EFFECT_B: begin
                p = s[0] ? 5'h0E : 5'h0B;
            end
            `RSM_WAIL_EFFECT_C: begin
                p = 5'h04 + {2'b00, s};
            end
            default: p = `RSM_PITCH_END;
        endcase
        return p;
    endfunction

    // half period lookup, built at elaboration
    logic [HP_W-1:0] half_tab [0:`RSM_PITCH_LAST];
    for (genvar g = 0; g <= `RSM_PITCH_LAST; g++) begin : g_half
        assign half_tab[g] = HP_W'(CLK_HZ / (2 * note_hz(g)));
    end

    // paired command bytes
    logic [7:0] code;
    logic [7:0] qual;
    logic       cmd_valid;

    rsm_byte_pair u_pair (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .rx_byte_i   (rx_byte_i),
        .rx_valid_i  (rx_valid_i),
        .code_o      (code),
        .qual_o      (qual),
        .cmd_valid_o (cmd_valid)
    );

    // command decode
    logic is_sound;
    logic is_motor;
    logic is_init;
    logic is_known;
    assign is_sound = cmd_valid && code == `RSM_SOUND_PLAY_CODE;
    assign is_motor = cmd_valid && code == `RSM_MOTOR_CONFIG_CODE;
    assign is_init  = cmd_valid && code == `RSM_ROBOT_INIT_CODE;
    assign is_known = is_sound | is_motor | is_init;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_taken_o   <= 1'b0;
            cmd_ignored_o <= 1'b0;
        end else begin
            cmd_taken_o   <= is_known;
            cmd_ignored_o <= cmd_valid & ~is_known;
        end
    end

    // motor configuration
    logic       motor_cfg_reg;
    logic [2:0] motor_type_reg;
    logic       encoder_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            motor_cfg_reg  <= 1'b0;
            motor_type_reg <= `RSM_MOTOR_TYPE_RST;
            encoder_reg    <= 1'b0;
        end else if (is_motor) begin
            motor_cfg_reg  <= 1'b1;
            motor_type_reg <= qual[`RSM_MOTOR_TYPE_MSB:`RSM_MOTOR_TYPE_LSB];
            encoder_reg    <= qual[`RSM_ENCODER_BIT];
        end
    end

    assign motor_configured_o = motor_cfg_reg;
    assign motor_type_o       = motor_type_reg;
    assign encoder_en_o       = encoder_reg;

    // pins carry drive only for configured small brushed motors
    logic direct_ok;
    assign direct_ok = motor_cfg_reg && motor_type_reg == `RSM_SMALL_BRUSHED_MOTOR_TYPE;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            left_drive_o   <= 2'b00;
            right_drive_o  <= 2'b00;
            direct_drive_o <= 1'b0;
        end else begin
            left_drive_o   <= direct_ok ? left_drive_i : 2'b00;
            right_drive_o  <= direct_ok ? right_drive_i : 2'b00;
            direct_drive_o <= direct_ok;
        end
    end

    // start-up request held for the first cycle out of reset
    logic boot_reg;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    // start of a new sound, which replaces any in progress
    logic       start_efx;
    logic       start_note;
    logic [3:0] start_efx_id;
    assign start_note   = is_sound && qual[`RSM_QUAL_NOTE_BIT];
    assign start_efx    = boot_reg || is_init ||
                          (is_sound && !qual[`RSM_QUAL_NOTE_BIT]
                           && qual[6:0] < 7'(`RSM_EFFECT_COUNT));
    assign start_efx_id = is_sound ? qual[3:0] : `RSM_STARTUP_EFFECT;

    // sound sequencer
    rsm_pkg::rsm_state_t state_reg;
    logic                is_note_reg;
    logic [3:0]          efx_reg;
    logic [2:0]          step_reg;
    logic [4:0]          pitch_reg;
    logic [31:0]         cyc_reg;
    logic [3:0]          units_reg;
    logic                restart_reg;

    logic [31:0] unit_len;
    logic [4:0]  next_pitch;
    logic [4:0]  note_pitch;
    logic [3:0]  note_units;
    assign unit_len   = is_note_reg ? 32'(QUARTER_CYCLES - 1) : 32'(STEP_CYCLES - 1);
    assign next_pitch = efx_pitch(efx_reg, step_reg + 3'h1);
    assign note_pitch = qual[`RSM_QUAL_PITCH_MSB:`RSM_QUAL_PITCH_LSB] > `RSM_PITCH_LAST
                        ? `RSM_PITCH_REST : qual[`RSM_QUAL_PITCH_MSB:`RSM_QUAL_PITCH_LSB];

    // length field to quarter counts
    always_comb begin
        note_units = 4'h1;
        case (rsm_pkg::rsm_len_t'(qual[`RSM_QUAL_LEN_MSB:`RSM_QUAL_LEN_LSB]))
            rsm_pkg::RSM_LEN_QUARTER: note_units = 4'h1;
            rsm_pkg::RSM_LEN_HALF:    note_units = 4'h2;
            rsm_pkg::RSM_LEN_WHOLE:   note_units = 4'h4;
            rsm_pkg::RSM_LEN_DOUBLE:  note_units = 4'h8;
            default:                  note_units = 4'h1;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg   <= rsm_pkg::RSM_IDLE;
            is_note_reg <= 1'b0;
            efx_reg     <= `RSM_STARTUP_EFFECT;
            step_reg    <= 3'h0;
            pitch_reg   <= `RSM_PITCH_REST;
            cyc_reg     <= 32'h0;
            units_reg   <= 4'h0;
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= 1'b0;
            if (start_note) begin
                state_reg   <= rsm_pkg::RSM_PLAY;
                is_note_reg <= 1'b1;
                step_reg    <= 3'h0;
                pitch_reg   <= note_pitch;
                cyc_reg     <= 32'(QUARTER_CYCLES - 1);
                units_reg   <= note_units;
                restart_reg <= 1'b1;
            end else if (start_efx) begin
                state_reg   <= rsm_pkg::RSM_PLAY;
                is_note_reg <= 1'b0;
                efx_reg     <= start_efx_id;
                step_reg    <= 3'h0;
                pitch_reg   <= efx_pitch(start_efx_id, 3'h0);
                cyc_reg     <= 32'(STEP_CYCLES - 1);
                units_reg   <= 4'h1;
                restart_reg <= 1'b1;
            end else begin
                case (state_reg)
                    rsm_pkg::RSM_IDLE: begin
                        cyc_reg <= 32'h0;
                    end
                    rsm_pkg::RSM_PLAY: begin
                        if (cyc_reg != 32'h0) begin
                            cyc_reg <= cyc_reg - 32'h1;
                        end else if (units_reg > 4'h1) begin
                            units_reg <= units_reg - 4'h1;
                            cyc_reg   <= unit_len;
                        end else if (is_note_reg || step_reg == 3'(`RSM_EFFECT_STEPS - 1)
                                     || next_pitch == `RSM_PITCH_END) begin
                            state_reg <= rsm_pkg::RSM_IDLE;
                            pitch_reg <= `RSM_PITCH_REST;
                        end else begin
                            step_reg    <= step_reg + 3'h1;
                            pitch_reg   <= next_pitch;
                            cyc_reg     <= unit_len;
                            restart_reg <= 1'b1;
                        end
                    end
                    default: state_reg <= rsm_pkg::RSM_IDLE;
                endcase
            end
        end
    end

    // rests keep the sequencer running with the buzzer quiet
    logic            tone_en;
    logic [HP_W-1:0] tone_half;
    assign tone_en   = state_reg == rsm_pkg::RSM_PLAY && pitch_reg <= `RSM_PITCH_LAST;
    assign tone_half = tone_en ? half_tab[pitch_reg] : HP_W'(1);
    assign sound_active_o = state_reg == rsm_pkg::RSM_PLAY;

    rsm_tone_gen #(
        .HP_W (HP_W)
    ) u_tone (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (tone_en),
        .restart_i (restart_reg),
        .half_i    (tone_half),
        .tone_o    (sound_o)
    );

endmodule

// ---- hw/rsm_tone_gen.sv ----
// square wave generator for the buzzer
// assumes the half period is held stable while enabled
`timescale 1ns/1ps
module rsm_tone_gen #(
    parameter int HP_W = 20
) (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            sys_rst_i,
    // control
    input  wire logic            en_i,
    input  wire logic            restart_i,
    input  wire logic [HP_W-1:0] half_i,
    // buzzer
    output logic                 tone_o
);

    logic [HP_W-1:0] cnt_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
            tone_o  <= 1'b0;
        end else if (!en_i || restart_i) begin
            cnt_reg <= '0;
            tone_o  <= 1'b0;
        end else if (cnt_reg >= half_i - HP_W'(1)) begin
            cnt_reg <= '0;
            tone_o  <= ~tone_o;
        end else begin
            cnt_reg <= cnt_reg + HP_W'(1);
        end
    end

endmodule

// ---- pkg/rsm_cfg.svh ----
// constants of the sound and motor command interpreter
// assumes a single 100 MHz system clock; all codes are internal encodings
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH

// command codes carried in the first byte
`define RSM_SOUND_PLAY_CODE      8'h01
`define RSM_MOTOR_CONFIG_CODE    8'h02
`define RSM_ROBOT_INIT_CODE      8'h03

// sound qualifier layout
`define RSM_QUAL_NOTE_BIT        7
`define RSM_QUAL_LEN_MSB         6
`define RSM_QUAL_LEN_LSB         5
`define RSM_QUAL_PITCH_MSB       4
`define RSM_QUAL_PITCH_LSB       0

// effect qualifier values
`define RSM_DRIP_EFFECT_A        4'h0
`define RSM_DRIP_EFFECT_B        4'h1
`define RSM_STARTUP_EFFECT       4'h2
`define RSM_LOW_PITCH_EFFECT     4'h3
`define RSM_DOUBLE_CHIRP_EFFECT  4'h4
`define RSM_TRIPLE_CHIRP_EFFECT  4'h5
`define RSM_PHASOR_EFFECT        4'h6
`define RSM_WAIL_EFFECT_A        4'h7
`define RSM_WAIL_EFFECT_B        4'h8
`define RSM_WAIL_EFFECT_C        4'h9
`define RSM_EFFECT_COUNT         4'hA

// pitch indices: 0..6 lower octave c..b, 7..13 middle, 14..20 upper
`define RSM_NOTES_PER_OCTAVE     7
`define RSM_PITCH_LAST           5'h14
`define RSM_PITCH_REST           5'h15
`define RSM_PITCH_END            5'h1F
`define RSM_EFFECT_STEPS         8

// middle octave frequencies in hz, c..b
`define RSM_NOTE_C_HZ            262
`define RSM_NOTE_D_HZ            294
`define RSM_NOTE_E_HZ            330
`define RSM_NOTE_F_HZ            349
`define RSM_NOTE_G_HZ            392
`define RSM_NOTE_A_HZ            440
`define RSM_NOTE_B_HZ            494

// motor qualifier layout
`define RSM_MOTOR_TYPE_MSB       2
`define RSM_MOTOR_TYPE_LSB       0
`define RSM_ENCODER_BIT          3
`define RSM_SMALL_BRUSHED_MOTOR_TYPE 3'h0
`define RSM_MOTOR_TYPE_RST       3'h0

// timing
`define RSM_CLK_HZ               100000000
`define RSM_QUARTER_NOTE_MS      125
`define RSM_EFFECT_STEP_MS       40
`define RSM_MS_PER_S             1000

`endif

// ---- pkg/rsm_pkg.sv ----
// types of the sound and motor command interpreter
// constants live in rsm_cfg.svh
package rsm_pkg;

    typedef enum logic [0:0] {
        RSM_IDLE = 1'b0,
        RSM_PLAY = 1'b1
    } rsm_state_t;

    typedef enum logic [1:0] {
        RSM_LEN_QUARTER = 2'b00,
        RSM_LEN_HALF    = 2'b01,
        RSM_LEN_WHOLE   = 2'b10,
        RSM_LEN_DOUBLE  = 2'b11
    } rsm_len_t;

endpackage

// ---- tb/robot_sound_motor_cmd_test.sv ----
// self-checking bench of the sound and motor command interpreter
// assumes shortened timing: 1 ms is 1000 cycles of clk_i
`timescale 1ns/1ps
module robot_sound_motor_cmd_test;
    localparam int STEP = 1000;
    logic       clk_i = 1'b0;
    logic       sys_rst_i;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic [1:0] left_drive_i;
    logic [1:0] right_drive_i;
    logic [1:0] left_drive_o;
    logic [1:0] right_drive_o;
    logic       motor_configured_o;
    logic [2:0] motor_type_o;
    logic       encoder_en_o;
    logic       direct_drive_o;
    logic       sound_o;
    logic       sound_active_o;
    logic       cmd_taken_o;
    logic       cmd_ignored_o;
    int         n_fail = 0;
    int         cmp_count = 0;

    always #5 clk_i = ~clk_i;

    rsm_host_model i_host (.clk_i(clk_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));

    rsm_cmd_core #(.CLK_HZ(1000000), .QUARTER_MS(1), .EFFECT_STEP_MS(1), .HP_W(20)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
        .left_drive_i(left_drive_i), .right_drive_i(right_drive_i), .left_drive_o(left_drive_o),
        .right_drive_o(right_drive_o), .motor_configured_o(motor_configured_o), .motor_type_o(motor_type_o),
        .encoder_en_o(encoder_en_o), .direct_drive_o(direct_drive_o), .sound_o(sound_o),
        .sound_active_o(sound_active_o), .cmd_taken_o(cmd_taken_o), .cmd_ignored_o(cmd_ignored_o));

    task automatic wrap_up;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_span(input int got, input int exp, input int tol);
        cmp_count++;
        if (got < exp - tol || got > exp + tol) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_active(input logic lvl);
        int i;
        for (i = 0; i < 20000 && sound_active_o !== lvl; i++) tick(1);
        if (i == 20000) begin
            chk_val(8'h00, 8'h01);
            wrap_up();
        end
    endtask

    // length of one sound in cycles
    task automatic play_len(input int exp);
        int n;
        wait_active(1'b1);
        n = 0;
        while (sound_active_o === 1'b1 && n < 20000) begin
            tick(1);
            n++;
        end
        chk_span(n, exp, 4);
    endtask

    // cycles between the first two buzzer edges
    task automatic half_of(output int n);
        logic s;
        int   i;
        s = sound_o;
        for (i = 0; i < 20000 && sound_o === s; i++) tick(1);
        s = sound_o;
        n = 0;
        while (sound_o === s && n < 20000) begin
            tick(1);
            n++;
        end
    endtask

    task automatic sc_boot;
        tick(1);
        chk_val({7'h00, sound_active_o}, 8'h01);
        play_len(4 * STEP);
    endtask

    task automatic sc_motor;
        left_drive_i = 2'h3;
        right_drive_i = 2'h2;
        tick(3);
        chk_val({4'h0, left_drive_o, right_drive_o}, 8'h00);
        i_host.send_cmd(8'h02, 8'h08);
        tick(1);
        chk_val({7'h00, cmd_taken_o}, 8'h01);
        tick(1);
        chk_val({2'h0, motor_configured_o, motor_type_o, encoder_en_o, direct_drive_o}, 8'h23);
        tick(1);
        chk_val({4'h0, left_drive_o, right_drive_o}, 8'h0E);
        i_host.send_cmd(8'h02, 8'hF9);
        tick(2);
        chk_val({2'h0, motor_configured_o, motor_type_o, encoder_en_o, direct_drive_o}, 8'h26);
        tick(1);
        chk_val({4'h0, left_drive_o, right_drive_o}, 8'h00);
        i_host.send_cmd(8'h55, 8'h02);
        tick(1);
        chk_val({6'h00, cmd_taken_o, cmd_ignored_o}, 8'h01);
        chk_val({2'h0, motor_configured_o, motor_type_o, encoder_en_o, direct_drive_o}, 8'h26);
    endtask

    task automatic sc_effects;
        for (int e = 0; e < 10; e++) begin
            i_host.send_cmd(8'h01, 8'(e));
            tick(1);
            chk_val({6'h00, cmd_taken_o, sound_active_o}, 8'h03);
        end
        i_host.send_cmd(8'h02, 8'h08);
        tick(1);
        chk_val({6'h00, cmd_taken_o, sound_active_o}, 8'h03);
        wait_active(1'b0);
        i_host.send_cmd(8'h01, 8'h0A);
        tick(1);
        chk_val({6'h00, cmd_taken_o, sound_active_o}, 8'h02);
    endtask

    task automatic sc_init;
        i_host.send_cmd(8'h03, 8'h00);
        play_len(4 * STEP);
        chk_val({2'h0, motor_configured_o, motor_type_o, encoder_en_o, direct_drive_o}, 8'h23);
    endtask

    task automatic sc_notes;
        logic [7:0] pitch [3] = '{8'h14, 8'h00, 8'h0C};
        int         half  [3] = '{506, 3816, 1136};
        int         n;
        for (int l = 0; l < 4; l++) begin
            i_host.send_cmd(8'h01, 8'h94 | 8'(l << 5));
            play_len((1 << l) * STEP);
        end
        for (int p = 0; p < 3; p++) begin
            i_host.send_cmd(8'h01, 8'hE0 | pitch[p]);
            half_of(n);
            chk_span(n, half[p], 2);
        end
    endtask

    initial begin
        sys_rst_i = 1'b1;
        left_drive_i = 2'h0;
        right_drive_i = 2'h0;
        repeat (16) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        sc_boot();
        sc_motor();
        sc_effects();
        sc_init();
        sc_notes();
        wrap_up();
    end
endmodule

// ---- tb/rsm_cmd_chk.sv ----
// concurrent checks of the sound and motor command interpreter
// assumes bind to rsm_cmd_core; sees its ports only
`timescale 1ns/1ps
`include "rsm_cfg.svh"
module rsm_cmd_chk (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // inputs
    input wire logic [7:0] rx_byte_i,
    input wire logic       rx_valid_i,
    input wire logic [1:0] left_drive_i,
    input wire logic [1:0] right_drive_i,
    // outputs
    input wire logic [1:0] left_drive_o,
    input wire logic [1:0] right_drive_o,
    input wire logic       motor_configured_o,
    input wire logic [2:0] motor_type_o,
    input wire logic       encoder_en_o,
    input wire logic       direct_drive_o,
    input wire logic       sound_o,
    input wire logic       sound_active_o,
    input wire logic       cmd_taken_o,
    input wire logic       cmd_ignored_o
);
    logic       phase_reg;
    logic [7:0] code_reg;
    logic [7:0] qual_reg;
    logic       qual_take;
    logic       known;

    assign qual_take = rx_valid_i && phase_reg;
    assign known = (code_reg == `RSM_SOUND_PLAY_CODE) || (code_reg == `RSM_MOTOR_CONFIG_CODE)
                   || (code_reg == `RSM_ROBOT_INIT_CODE);

    // byte parity: odd byte is the code
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_reg <= 1'b0;
        end else if (rx_valid_i) begin
            phase_reg <= ~phase_reg;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            code_reg <= 8'h00;
        end else if (rx_valid_i && !phase_reg) begin
            code_reg <= rx_byte_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            qual_reg <= 8'h00;
        end else if (qual_take) begin
            qual_reg <= rx_byte_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_motor_qual;
        qual_take && code_reg == `RSM_MOTOR_CONFIG_CODE;
    endsequence
    sequence s_config_set;
        motor_configured_o && motor_type_o == qual_reg[2:0] && encoder_en_o == qual_reg[`RSM_ENCODER_BIT];
    endsequence
    sequence s_unknown;
        qual_take && !known;
    endsequence

    a_boot_tone: assert property ($fell(sys_rst_i) |=> sound_active_o)
        else $error("no start-up sound after reset");
    a_init_replay: assert property (qual_take && code_reg == `RSM_ROBOT_INIT_CODE |-> ##2 sound_active_o
        && $stable(motor_type_o)) else $error("init command did not start the sound");
    a_status_cause: assert property ((cmd_taken_o || cmd_ignored_o) |-> $past(qual_take, 2))
        else $error("status pulse without a complete byte pair");
    a_known_taken: assert property (qual_take && known |-> ##2 cmd_taken_o && !cmd_ignored_o)
        else $error("known command not taken");
    a_sound_start: assert property (qual_take && code_reg == `RSM_SOUND_PLAY_CODE
        && (rx_byte_i[7] || rx_byte_i < 8'h0A) |-> ##2 sound_active_o) else $error("sound did not start");
    a_motor_decode: assert property (s_motor_qual |-> ##2 s_config_set)
        else $error("motor configuration differs from qualifier");
    a_direct_type: assert property (direct_drive_o == $past(motor_configured_o
        && motor_type_o == `RSM_SMALL_BRUSHED_MOTOR_TYPE)) else $error("direct drive flag wrong");
    a_drive_gate: assert property (!direct_drive_o |-> left_drive_o == 2'h0
        && right_drive_o == 2'h0) else $error("motor pins driven while unconfigured");
    a_drive_pass: assert property (direct_drive_o |-> left_drive_o == $past(left_drive_i)
        && right_drive_o == $past(right_drive_i)) else $error("motor pins do not follow requests");
    a_unknown_drop: assert property (s_unknown |-> ##2 cmd_ignored_o && !cmd_taken_o)
        else $error("unknown code not dropped");
    a_unknown_keep: assert property (s_unknown |-> ##1 ($stable(motor_type_o) && $stable(encoder_en_o)
        && $stable(motor_configured_o))[*3]) else $error("unknown code changed motor state");
endmodule

bind rsm_cmd_core rsm_cmd_chk i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_byte_i(rx_byte_i),
    .rx_valid_i(rx_valid_i), .left_drive_i(left_drive_i), .right_drive_i(right_drive_i),
    .left_drive_o(left_drive_o), .right_drive_o(right_drive_o), .motor_configured_o(motor_configured_o),
    .motor_type_o(motor_type_o), .encoder_en_o(encoder_en_o), .direct_drive_o(direct_drive_o),
    .sound_o(sound_o), .sound_active_o(sound_active_o), .cmd_taken_o(cmd_taken_o),
    .cmd_ignored_o(cmd_ignored_o));

// ---- tb/rsm_host_model.sv ----
// host side of the command link: sends two-byte commands
// assumes the bench calls send_cmd after reset has been released
`timescale 1ns/1ps
module rsm_host_model (
    // clock
    input  wire logic       clk_i,
    // byte stream
    output logic      [7:0] rx_byte_o,
    output logic            rx_valid_o
);
    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
    end

    // only motor, sound and robot init commands exist here, so no sensor setup precedes motors
    task automatic send_cmd(input logic [7:0] code, input logic [7:0] qual);
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_byte_o = code;
        @(posedge clk_i);
        #1;
        rx_byte_o = qual;
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        // idle bus shows no stale byte
        rx_byte_o = ~qual;
    endtask
endmodule
